//--- hw/blsb_consts.svh
`ifndef BLSB_CONSTS_SVH
`define BLSB_CONSTS_SVH

`define BLSB_RESULT_RESET 8'h00
`define BLSB_CARRY_RESET  1'b0
`define BLSB_ZERO_RESET   1'b0
`define BLSB_BIT_MSB      3'h7
`define BLSB_BIT_LSB      3'h0
`define BLSB_LATENCY      1

`endif

//--- hw/blsb_pkg.sv
package blsb_pkg;

  typedef enum logic [4:0] {
    BLSB_OP_NOP,
    BLSB_OP_AND,
    BLSB_OP_OR,
    BLSB_OP_XOR,
    BLSB_OP_NOT,
    BLSB_OP_ARITH_SHIFT_LEFT,
    BLSB_OP_ARITH_SHIFT_RIGHT,
    BLSB_OP_LOGIC_SHIFT_LEFT,
    BLSB_OP_LOGIC_SHIFT_RIGHT,
    BLSB_OP_ROTATE_LEFT,
    BLSB_OP_ROTATE_RIGHT,
    BLSB_OP_ROTATE_LEFT_VIA_CARRY,
    BLSB_OP_ROTATE_RIGHT_VIA_CARRY,
    BLSB_OP_BIT_SET,
    BLSB_OP_BIT_CLEAR,
    BLSB_OP_BIT_INVERT,
    BLSB_OP_BIT_TEST,
    BLSB_OP_CARRY_AND_BIT,
    BLSB_OP_CARRY_AND_INVERTED_BIT,
    BLSB_OP_CARRY_OR_BIT,
    BLSB_OP_CARRY_OR_INVERTED_BIT,
    BLSB_OP_CARRY_XOR_BIT,
    BLSB_OP_CARRY_XOR_INVERTED_BIT,
    BLSB_OP_BIT_LOAD_TO_CARRY,
    BLSB_OP_INVERTED_BIT_LOAD_TO_CARRY,
    BLSB_OP_CARRY_STORE_TO_BIT,
    BLSB_OP_INVERTED_CARRY_STORE_TO_BIT
  } blsb_op_t;

  // request from the decoder/sequencer
  typedef struct packed {
    blsb_op_t    op;
    logic [7:0]  dest;        // destination register or memory byte
    logic [7:0]  source;      // source_register or immediate byte
    logic        use_imm;     // second operand / bit number from immediate
    logic [7:0]  imm;         // immediate byte; bit number in imm[2:0]
    logic        carry_in;    // condition_code_register carry
    logic        zero_in;     // condition_code_register zero
  } blsb_req_t;

  // answer to the register file / memory access and flag logic
  typedef struct packed {
    logic [7:0]  result;
    logic        result_we;   // result must be written back
    logic        carry;
    logic        carry_we;    // carry flag changed by this operation
    logic        zero;
    logic        zero_we;     // zero flag changed by this operation
    logic        illegal;     // register bit number on immediate-only op
  } blsb_rsp_t;

endpackage

//--- hw/blsb_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "blsb_consts.svh"

module blsb_unit (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              req_valid,
  input  wire blsb_pkg::blsb_req_t req,
  output var  logic              rsp_valid,
  output var  blsb_pkg::blsb_rsp_t rsp
);

  function automatic logic [7:0] bit_mask(input logic [2:0] pos);
    bit_mask = 8'h01 << pos;
  endfunction

  function automatic logic bit_pick(input logic [7:0] v,
                                    input logic [2:0] pos);
    bit_pick = v[pos];
  endfunction

  wire blsb_pkg::blsb_op_t op = req.op;
  wire logic [7:0] d  = req.dest;
  wire logic       c  = req.carry_in;

  // write one bit value into the masked position
  function automatic logic [7:0] put_bit(input logic [7:0] v,
                                         input logic [7:0] m,
                                         input logic       b);
    put_bit = b ? (v | m) : (v & ~m);
  endfunction

  // second operand for the byte logic group
  wire logic [7:0] opnd = req.use_imm ? req.imm : req.source;

  // bit number: immediate field or low bits of a register
  wire logic [2:0] bit_no =
    req.use_imm ? req.imm[2:0] : req.source[2:0];

  // byte logic decode
  wire logic is_and   = (op == blsb_pkg::BLSB_OP_AND);
  wire logic is_or    = (op == blsb_pkg::BLSB_OP_OR);
  wire logic is_xor   = (op == blsb_pkg::BLSB_OP_XOR);
  wire logic is_not   = (op == blsb_pkg::BLSB_OP_NOT);

  // shifts and rotates
  wire logic is_asl   = (op == blsb_pkg::BLSB_OP_ARITH_SHIFT_LEFT);
  wire logic is_asr   = (op == blsb_pkg::BLSB_OP_ARITH_SHIFT_RIGHT);
  wire logic is_lsl   = (op == blsb_pkg::BLSB_OP_LOGIC_SHIFT_LEFT);
  wire logic is_lsr   = (op == blsb_pkg::BLSB_OP_LOGIC_SHIFT_RIGHT);
  wire logic is_rol   = (op == blsb_pkg::BLSB_OP_ROTATE_LEFT);
  wire logic is_ror   = (op == blsb_pkg::BLSB_OP_ROTATE_RIGHT);
  wire logic is_rlc   = (op == blsb_pkg::BLSB_OP_ROTATE_LEFT_VIA_CARRY);
  wire logic is_rrc   = (op == blsb_pkg::BLSB_OP_ROTATE_RIGHT_VIA_CARRY);

  // single-bit byte operations
  wire logic is_bit_set_op  = (op == blsb_pkg::BLSB_OP_BIT_SET);
  wire logic is_bit_clear_op  = (op == blsb_pkg::BLSB_OP_BIT_CLEAR);
  wire logic is_binv  = (op == blsb_pkg::BLSB_OP_BIT_INVERT);
  wire logic is_bit_test_op  = (op == blsb_pkg::BLSB_OP_BIT_TEST);

  // carry flag boolean operations
  wire logic is_cand  = (op == blsb_pkg::BLSB_OP_CARRY_AND_BIT);
  wire logic is_candi = (op == blsb_pkg::BLSB_OP_CARRY_AND_INVERTED_BIT);
  wire logic is_cor   = (op == blsb_pkg::BLSB_OP_CARRY_OR_BIT);
  wire logic is_cori  = (op == blsb_pkg::BLSB_OP_CARRY_OR_INVERTED_BIT);
  wire logic is_cxor  = (op == blsb_pkg::BLSB_OP_CARRY_XOR_BIT);
  wire logic is_cxori = (op == blsb_pkg::BLSB_OP_CARRY_XOR_INVERTED_BIT);

  // carry load and store
  wire logic is_cld   = (op == blsb_pkg::BLSB_OP_BIT_LOAD_TO_CARRY);
  wire logic is_icld  =
    (op == blsb_pkg::BLSB_OP_INVERTED_BIT_LOAD_TO_CARRY);
  wire logic is_cst   = (op == blsb_pkg::BLSB_OP_CARRY_STORE_TO_BIT);
  wire logic is_icst  =
    (op == blsb_pkg::BLSB_OP_INVERTED_CARRY_STORE_TO_BIT);

  // inverted variants take their bit number from the immediate only
  wire logic imm_only_op =
    is_candi || is_cori || is_cxori || is_icld || is_icst;
  wire logic bad_src = imm_only_op && !req.use_imm;

  wire logic [7:0] mask = bit_mask(bit_no);
  wire logic       sel  = bit_pick(d, bit_no);

  // byte results
  wire logic [7:0] and_res = d & opnd;
  wire logic [7:0] or_res  = d | opnd;
  wire logic [7:0] xor_res = d ^ opnd;
  wire logic [7:0] not_res = ~d;
  wire logic [7:0] shl_res = {d[6:0], 1'b0};
  wire logic [7:0] asr_res = {d[7], d[7:1]};
  wire logic [7:0] lsr_res = {1'b0, d[7:1]};
  wire logic [7:0] rol_res = {d[6:0], d[7]};
  wire logic [7:0] ror_res = {d[0], d[7:1]};
  wire logic [7:0] rlc_res = {d[6:0], c};
  wire logic [7:0] rrc_res = {c, d[7:1]};
  wire logic [7:0] set_res = put_bit(d, mask, 1'b1);
  wire logic [7:0] clr_res = put_bit(d, mask, 1'b0);
  wire logic [7:0] inv_res = d ^ mask;
  wire logic [7:0] st_res  = put_bit(d, mask, c);
  wire logic [7:0] ist_res = put_bit(d, mask, ~c);

  // bits leaving the byte at either end
  wire logic msb_out = d[7];
  wire logic lsb_out = d[0];

  // carry results of the flag operations
  wire logic cand_c  = c & sel;
  wire logic candi_c = c & ~sel;
  wire logic cor_c   = c | sel;
  wire logic cori_c  = c | ~sel;
  wire logic cxor_c  = c ^ sel;
  wire logic cxori_c = c ^ ~sel;
  wire logic cld_c   = sel;
  wire logic icld_c  = ~sel;

  // zero flag of the bit test
  wire logic test_zero = ~sel;

  // operations that write the byte back
  wire logic res_group =
    is_and ||
    is_or ||
    is_xor ||
    is_not ||
    is_asl ||
    is_asr ||
    is_lsl ||
    is_lsr ||
    is_rol ||
    is_ror ||
    is_rlc ||
    is_rrc ||
    is_bit_set_op ||
    is_bit_clear_op ||
    is_binv ||
    is_cst ||
    is_icst;

  // operations that change the carry flag
  wire logic car_group =
    is_asl ||
    is_asr ||
    is_lsl ||
    is_lsr ||
    is_rol ||
    is_ror ||
    is_rlc ||
    is_rrc ||
    is_cand ||
    is_candi ||
    is_cor ||
    is_cori ||
    is_cxor ||
    is_cxori ||
    is_cld ||
    is_icld;

  // operations that change the zero flag
  wire logic zero_group = is_bit_test_op;

  // a refused request writes nothing back
  wire logic next_result_we = res_group && !bad_src;
  wire logic next_carry_we  = car_group && !bad_src;

  logic [7:0]          next_result;
  logic                next_carry;
  blsb_pkg::blsb_rsp_t next_rsp;

  // per-operation byte and carry
  always_comb begin
    next_result = 8'h00;
    next_carry  = c;
    case (op)
      blsb_pkg::BLSB_OP_NOP: begin
        next_result = 8'h00;
        next_carry  = c;
      end

      // byte logic
      blsb_pkg::BLSB_OP_AND: begin
        next_result = and_res;
        next_carry  = c;
      end
      blsb_pkg::BLSB_OP_OR: begin
        next_result = or_res;
        next_carry  = c;
      end
      blsb_pkg::BLSB_OP_XOR: begin
        next_result = xor_res;
        next_carry  = c;
      end
      blsb_pkg::BLSB_OP_NOT: begin
        next_result = not_res;
        next_carry  = c;
      end

      // shifts and rotates
      blsb_pkg::BLSB_OP_ARITH_SHIFT_LEFT: begin
        next_result = shl_res;
        next_carry  = msb_out;
      end
      blsb_pkg::BLSB_OP_ARITH_SHIFT_RIGHT: begin
        next_result = asr_res;
        next_carry  = lsb_out;
      end
      blsb_pkg::BLSB_OP_LOGIC_SHIFT_LEFT: begin
        next_result = shl_res;
        next_carry  = msb_out;
      end
      blsb_pkg::BLSB_OP_LOGIC_SHIFT_RIGHT: begin
        next_result = lsr_res;
        next_carry  = lsb_out;
      end
      blsb_pkg::BLSB_OP_ROTATE_LEFT: begin
        next_result = rol_res;
        next_carry  = msb_out;
      end
      blsb_pkg::BLSB_OP_ROTATE_RIGHT: begin
        next_result = ror_res;
        next_carry  = lsb_out;
      end
      blsb_pkg::BLSB_OP_ROTATE_LEFT_VIA_CARRY: begin
        next_result = rlc_res;
        next_carry  = msb_out;
      end
      blsb_pkg::BLSB_OP_ROTATE_RIGHT_VIA_CARRY: begin
        next_result = rrc_res;
        next_carry  = lsb_out;
      end

      // single-bit byte operations
      blsb_pkg::BLSB_OP_BIT_SET: begin
        next_result = set_res;
        next_carry  = c;
      end
      blsb_pkg::BLSB_OP_BIT_CLEAR: begin
        next_result = clr_res;
        next_carry  = c;
      end
      blsb_pkg::BLSB_OP_BIT_INVERT: begin
        next_result = inv_res;
        next_carry  = c;
      end
      blsb_pkg::BLSB_OP_BIT_TEST: begin
        next_result = d;
        next_carry  = c;
      end

      // carry flag boolean operations
      blsb_pkg::BLSB_OP_CARRY_AND_BIT: begin
        next_result = 8'h00;
        next_carry  = cand_c;
      end
      blsb_pkg::BLSB_OP_CARRY_AND_INVERTED_BIT: begin
        next_result = 8'h00;
        next_carry  = candi_c;
      end
      blsb_pkg::BLSB_OP_CARRY_OR_BIT: begin
        next_result = 8'h00;
        next_carry  = cor_c;
      end
      blsb_pkg::BLSB_OP_CARRY_OR_INVERTED_BIT: begin
        next_result = 8'h00;
        next_carry  = cori_c;
      end
      blsb_pkg::BLSB_OP_CARRY_XOR_BIT: begin
        next_result = 8'h00;
        next_carry  = cxor_c;
      end
      blsb_pkg::BLSB_OP_CARRY_XOR_INVERTED_BIT: begin
        next_result = 8'h00;
        next_carry  = cxori_c;
      end

      // carry load and store
      blsb_pkg::BLSB_OP_BIT_LOAD_TO_CARRY: begin
        next_result = 8'h00;
        next_carry  = cld_c;
      end
      blsb_pkg::BLSB_OP_INVERTED_BIT_LOAD_TO_CARRY: begin
        next_result = 8'h00;
        next_carry  = icld_c;
      end
      blsb_pkg::BLSB_OP_CARRY_STORE_TO_BIT: begin
        next_result = st_res;
        next_carry  = c;
      end
      blsb_pkg::BLSB_OP_INVERTED_CARRY_STORE_TO_BIT: begin
        next_result = ist_res;
        next_carry  = c;
      end
      default: begin
        next_result = 8'h00;
        next_carry  = c;
      end
    endcase
  end

  // answer word; all fields zero while no request is present
  always_comb begin
    next_rsp = '0;
    if (req_valid) begin
      next_rsp.result    = next_result;
      next_rsp.result_we = next_result_we;
      // refused request keeps the incoming carry
      next_rsp.carry     = bad_src ? c : next_carry;
      next_rsp.carry_we  = next_carry_we;
      next_rsp.zero      = is_bit_test_op ? test_zero : req.zero_in;
      next_rsp.zero_we   = zero_group;
      next_rsp.illegal   = bad_src;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      rsp_valid <= req_valid;
      rsp       <= next_rsp;
    end
  end

endmodule // blsb_unit
`default_nettype wire

//--- dv/blsb_chk.sv
`timescale 1ns/10ps
`default_nettype none
module blsb_chk (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                req_valid,
  input wire blsb_pkg::blsb_req_t req,
  input wire logic                rsp_valid,
  input wire blsb_pkg::blsb_rsp_t rsp
);
  wire logic [7:0] opd = req.use_imm ? req.imm : req.source;
  wire logic       b   = req.dest[opd[2:0]];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  resp_pulse_a: assert property (req_valid |=> rsp_valid)
    else $error("no answer");
  idle_zero_a: assert property (!req_valid |=> !rsp_valid && rsp == '0)
    else $error("answer without request");
  and_result_a: assert property (
    req_valid && req.op == blsb_pkg::BLSB_OP_AND
    |=> rsp.result == $past(req.dest & opd)) else $error("and wrong");
  not_result_a: assert property (
    req_valid && req.op == blsb_pkg::BLSB_OP_NOT
    |=> rsp.result == ~$past(req.dest)) else $error("not wrong");
  arith_right_a: assert property (
    req_valid && req.op == blsb_pkg::BLSB_OP_ARITH_SHIFT_RIGHT
    |=> {rsp.result, rsp.carry} == {$past(req.dest[7]), $past(req.dest)})
    else $error("arith right wrong");
  rot_carry_a: assert property (
    req_valid && req.op == blsb_pkg::BLSB_OP_ROTATE_LEFT_VIA_CARRY
    |=> {rsp.carry, rsp.result} == {$past(req.dest), $past(req.carry_in)})
    else $error("rotate via carry wrong");
  bit_set_a: assert property (
    req_valid && req.op == blsb_pkg::BLSB_OP_BIT_SET
    |=> rsp.result == ($past(req.dest) | (8'h01 << $past(opd[2:0]))))
    else $error("bit set wrong");
  bit_test_a: assert property (
    req_valid && req.op == blsb_pkg::BLSB_OP_BIT_TEST
    |=> rsp.zero == !$past(b) && rsp.zero_we && !rsp.result_we)
    else $error("bit test wrong");
  bit_load_a: assert property (
    req_valid && req.op == blsb_pkg::BLSB_OP_BIT_LOAD_TO_CARRY
    |=> rsp.carry == $past(b) && rsp.carry_we) else $error("load wrong");
  imm_only_a: assert property (
    req_valid && !req.use_imm
    && req.op == blsb_pkg::BLSB_OP_CARRY_AND_INVERTED_BIT
    |=> rsp.illegal && !rsp.carry_we) else $error("not refused");
  cover property (rsp.illegal);
  cover property (rsp.zero_we && rsp.zero);
  cover property (rsp.carry_we && rsp.result_we);
endmodule // blsb_chk
bind blsb_unit blsb_chk blsb_chk_i (.clk(clk), .rst(rst),
  .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
`default_nettype wire

//--- dv/blsb_rf.sv
`timescale 1ns/10ps
`default_nettype none
// register byte and carry flag with write-back
module blsb_rf (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                rsp_valid,
  input  wire blsb_pkg::blsb_rsp_t rsp,
  input  wire logic [9:0]          ldv,
  output var  logic [7:0]          r,
  output var  logic                c
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= 8'h00;
      c <= 1'b0;
    end else if (ldv[9]) begin
      r <= ldv[7:0];
      c <= ldv[8];
    end else if (rsp_valid) begin
      r <= rsp.result_we ? rsp.result : r;
      c <= rsp.carry_we ? rsp.carry : c;
    end
  end
endmodule // blsb_rf
`default_nettype wire

//--- dv/blsb_unit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module blsb_unit_tb_top;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                req_valid = 1'b0;
  blsb_pkg::blsb_req_t req = '0;
  logic                rsp_valid;
  blsb_pkg::blsb_rsp_t rsp;
  blsb_pkg::blsb_rsp_t last;
  logic [9:0]          ldv = 10'h000;
  logic [7:0]          r;
  logic                c;
  int                  miscompares = 0;
  int                  checks_done = 0;
  always #10 clk = ~clk;
  blsb_unit blsb_unit_i (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
  blsb_rf blsb_rf_i (.clk(clk), .rst(rst), .rsp_valid(rsp_valid),
    .rsp(rsp), .ldv(ldv), .r(r), .c(c));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pre(logic [7:0] v, logic cv);
    @(posedge clk);
    ldv <= {1'b1, cv, v};
    @(posedge clk);
    ldv <= 10'h000;
  endtask
  task automatic run(logic [4:0] op, logic ui, logic [7:0] x);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{blsb_pkg::blsb_op_t'(op), r, x, ui, x, c, 1'b0};
    @(posedge clk);
    req_valid <= 1'b0;
    #1 last = rsp;
    @(posedge clk);
    #1;
  endtask
  task automatic t_logic;
    pre(8'hf0, 1'b0);
    run(5'h01, 1'b1, 8'h3c);
    chk(r, 8'h30);
    run(5'h02, 1'b0, 8'h0f);
    chk(r, 8'h3f);
    run(5'h03, 1'b1, 8'hff);
    chk(r, 8'hc0);
    run(5'h04, 1'b0, 8'h00);
    chk(r, 8'h3f);
    $display("logic ops done");
  endtask
  task automatic t_shift;
    logic [7:0] e[8] = '{8'h02, 8'hc0, 8'h02, 8'h40,
                         8'h03, 8'hc0, 8'h02, 8'hc0};
    for (int i = 0; i < 8; i++) begin
      pre(8'h81, i[0]);
      run(5'(5 + i), 1'b0, 8'h00);
      chk(r, e[i]);
      chk({7'h00, c}, 8'h01);
    end
    $display("shifts done");
  endtask
  task automatic t_bits;
    pre(8'ha5, 1'b0);
    run(5'h0d, 1'b1, 8'h06);
    chk(r, 8'he5);
    run(5'h0e, 1'b0, 8'hf7);
    chk(r, 8'h65);
    run(5'h0f, 1'b1, 8'h00);
    chk(r, 8'h64);
    run(5'h10, 1'b1, 8'h01);
    chk({7'h00, last.zero}, 8'h01);
    chk(r, 8'h64);
    $display("bit ops done");
  endtask
  task automatic t_carry;
    logic [7:0] w = 8'h9e;
    for (int i = 0; i < 8; i++) begin
      pre(8'h0a, 1'b1);
      run(5'(17 + i), 1'b1, 8'h02);
      chk({7'h00, c}, {7'h00, w[i]});
    end
    run(5'h19, 1'b1, 8'h02);
    chk(r, 8'h0e);
    run(5'h1a, 1'b1, 8'h01);
    chk(r, 8'h0c);
    run(5'h12, 1'b0, 8'h02);
    chk({7'h00, last.illegal}, 8'h01);
    chk({7'h00, c}, 8'h01);
    $display("carry ops done");
  endtask
  task automatic stop_test;
    $display("checks %0d bad %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_logic;
    t_shift;
    t_bits;
    t_carry;
    stop_test;
  end
endmodule // blsb_unit_tb_top
`default_nettype wire
